// *** src/tr_node_pkg.sv ***
// Purpose: shared constants and types for the token ring node block
// Assumes: 250 MHz node clock, 32-bit classic wishbone register access
// Notes: time figures kept in ms, cycle counts derived from the clock rate
package tr_node_pkg;
	localparam int CLK_HZ    = 250_000_000;
	localparam int SEC_MS    = 1000;
	localparam int RB_MAX_MS = 120;
	localparam int SEC_CYC   = CLK_HZ / 1000 * SEC_MS;
	localparam int RB_CYC    = CLK_HZ / 1000 * RB_MAX_MS;
	localparam int TW        = 28;

	// register byte offsets
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_CFG   = 8'h04;
	localparam logic [7:0] A_MSG   = 8'h08;
	localparam logic [7:0] A_STATE = 8'h0C;
	localparam logic [7:0] A_ACFG  = 8'h10;
	localparam logic [7:0] A_CNT   = 8'h20;

	// control word bits
	localparam int B_QUEUE  = 0;
	localparam int B_AUTO   = 1;
	localparam int B_SYNCON = 2;
	localparam int B_SYNCOF = 3;
	localparam int B_FORCE  = 4;
	localparam int B_REJOIN = 5;
	localparam int B_OFFL   = 6;
	localparam int B_REL    = 8;
	localparam int B_CLRF   = 12;

	// state word fields
	localparam int F_PEND  = 16;
	localparam int F_SYNC  = 17;
	localparam int F_OCC   = 18;
	localparam int F_FAULT = 20;
	localparam int F_NAKS  = 21;
	localparam int F_FAILS = 24;

	localparam logic [2:0]  NAK_LIMIT  = 3'h4;
	localparam logic [2:0]  FAIL_LIMIT = 3'h5;
	localparam logic [15:0] STAT_RB    = 16'hFFFF;
	localparam logic [15:0] STAT_OK    = 16'h0000;

	// diagnostic counter indices
	localparam int CNT_N     = 6;
	localparam int C_REFUSED = 0;
	localparam int C_DUPSYNC = 1;
	localparam int C_SELF    = 2;
	localparam int C_PROC    = 3;
	localparam int C_FWDFAIL = 4;
	localparam int C_DETECT  = 5;

	typedef struct packed {
		logic       fwd;
		logic [1:0] kind;
		logic [7:0] dest;
	} msg_t;

	typedef struct packed {
		logic [1:0] rate;
		logic [7:0] addr;
	} cfg_t;

	localparam cfg_t CFG_RST = '{rate: 2'h0, addr: 8'h01};
	localparam msg_t MSG_RST = '{fwd: 1'b0, kind: 2'h0, dest: 8'h00};

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_ENQ  = 3'b010,
		S_PKT  = 3'b100
	} st_t;
endpackage

// *** src/tr_node.sv ***
// Purpose: token ring node message handshake, sync ownership and diagnostics
// Assumes: link events are one-cycle pulses synchronous to i_clock
// Notes: registers reached over classic wishbone, one aligned word each
// Functional notes
// - send buffer enquiry before any message
// - free receive buffer gives positive reply
// - positive reply leads to packet, then reply
// - second positive reply delivers, passes token
// - refusal ends attempt, token passed on
// - refused message retried on next token
// - fourth refusal discards, counts refused send
// - both buffers occupied gives refusal reply
// - sync generator counts foreign sync messages
// - auto mode yields sync to lower address
// - token holder leaving triggers ring rebuild; going offline forces no rebuild here
// - leaving without token causes no rebuild
// - join, going online, rejoin force rebuild
// - count each self forced rebuild
// - processed request counter counts each one
// - each failed forwarding attempt counted
// - status reads minus one during rebuilds
// - status refreshed once per second only
// - rebuild must end within 120 ms
// - address and rate applied only at reset; code also applies them at rejoin
// - node can force and detect rebuilds
// - detected rebuild counted, status held second
// - no reply: five tries, each failure counted
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module tr_node
	import tr_node_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = SEC_CYC,
	parameter int unsigned RB_CYCLES  = RB_CYC
) (
	input  wire logic               i_clock,
	input  wire logic               i_rst_n,
	input  wire logic               i_clk_en,
	input  wire logic               i_wb_cyc,
	input  wire logic               i_wb_stb,
	input  wire logic               i_wb_we,
	input  wire logic [7:0]         i_wb_adr,
	input  wire logic [31:0]        i_wb_dat,
	input  wire logic [3:0]         i_wb_sel,
	output logic      [31:0]        o_wb_dat,
	output logic                    o_wb_ack,
	input  wire logic               i_token,
	input  wire logic               i_reply_ack,
	input  wire logic               i_reply_refuse,
	input  wire logic               i_reply_none,
	input  wire logic               i_rx_enquiry,
	input  wire logic               i_rx_packet_ok,
	input  wire logic               i_rx_noncyclic,
	input  wire logic               i_sync_seen,
	input  wire logic [7:0]         i_sync_src,
	input  wire logic               i_rebuild_seen,
	input  wire logic               i_rebuild_active,
	input  wire logic               i_go_online,
	output logic                    o_send_enquiry,
	output logic                    o_send_packet,
	output tr_node_pkg::msg_t       o_msg,
	output logic                    o_pass_token,
	output logic                    o_reply_ack,
	output logic                    o_reply_refuse,
	output logic                    o_force_rebuild,
	output logic                    o_sync_gen,
	output logic [15:0]             o_status,
	output logic                    o_ring_rebuild_indicator,
	output tr_node_pkg::cfg_t       o_cfg
);
	import tr_node_pkg::*;

	function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			wmask[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
		end
	endfunction

	function automatic logic cnt_hit(input logic [7:0] a);
		cnt_hit = (a >= A_CNT) && (a < A_CNT + 8'(4 * CNT_N)) && (a[1:0] == 2'h0);
	endfunction

	st_t         st;
	cfg_t        cfg_pend;
	msg_t        msg;
	logic        pending;
	logic [2:0]  naks;
	logic [2:0]  fails;
	logic        auto_sync;
	logic        offline;
	logic        joined;
	logic        fault;
	logic [1:0]  occ;
	logic [TW-1:0] sec_cnt;
	logic [TW-1:0] rb_cnt;
	logic        rb_win;
	logic        tick;
	logic        req;
	logic        wr;
	logic        wr_ctrl;
	logic [31:0] cw;
	logic [31:0] rdata;
	logic [15:0] cnt [CNT_N];
	logic [CNT_N-1:0] inc;
	logic        next_force;
	logic        rb_timeout;
	logic        fail_ev;
	logic        go;

	// bus slave
	assign req     = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr      = req && i_wb_we && i_clk_en;
	assign wr_ctrl = wr && (i_wb_adr == A_CTRL);
	assign cw      = wmask(32'h0000_0000, i_wb_dat, i_wb_sel);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else if (i_clk_en) begin
			o_wb_ack <= req;
			if (req && !i_wb_we)
				o_wb_dat <= rdata;
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		if (i_wb_adr == A_CTRL) begin
			rdata[B_AUTO] = auto_sync;
			rdata[B_OFFL] = offline;
		end else if (i_wb_adr == A_CFG)
			rdata[$bits(cfg_t)-1:0] = cfg_pend;
		else if (i_wb_adr == A_MSG)
			rdata[$bits(msg_t)-1:0] = msg;
		else if (i_wb_adr == A_STATE) begin
			rdata[15:0]          = o_status;
			rdata[F_PEND]        = pending;
			rdata[F_SYNC]        = o_sync_gen;
			rdata[F_OCC +: 2]    = occ;
			rdata[F_FAULT]       = fault;
			rdata[F_NAKS +: 3]   = naks;
			rdata[F_FAILS +: 3]  = fails;
		end else if (i_wb_adr == A_ACFG)
			rdata[$bits(cfg_t)-1:0] = o_cfg;
		else if (cnt_hit(i_wb_adr))
			rdata[15:0] = cnt[3'((i_wb_adr - A_CNT) >> 2)];
	end

	// software held settings
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_pend  <= CFG_RST;
			msg       <= MSG_RST;
			auto_sync <= 1'b0;
			offline   <= 1'b0;
		end else if (i_clk_en) begin
			if (wr && i_wb_adr == A_CFG)
				cfg_pend <= ($bits(cfg_t))'(wmask(32'(cfg_pend), i_wb_dat, i_wb_sel));
			if (wr && i_wb_adr == A_MSG && !pending)
				msg <= ($bits(msg_t))'(wmask(32'(msg), i_wb_dat, i_wb_sel));
			if (wr_ctrl && i_wb_sel[0]) begin
				auto_sync <= i_wb_dat[B_AUTO];
				offline   <= i_wb_dat[B_OFFL];
			end
		end
	end

	// active settings load only at join or rejoin
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cfg  <= CFG_RST;
			joined <= 1'b0;
		end else if (i_clk_en) begin
			joined <= 1'b1;
			if (!joined || (wr_ctrl && cw[B_REJOIN]))
				o_cfg <= cfg_pend;
		end
	end

	// message sender
	assign go      = !offline && !i_rebuild_active;
	assign fail_ev = i_reply_none && ((st == S_ENQ) || (st == S_PKT));

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st             <= S_IDLE;
			pending        <= 1'b0;
			naks           <= 3'h0;
			fails          <= 3'h0;
			o_send_enquiry <= 1'b0;
			o_send_packet  <= 1'b0;
			o_pass_token   <= 1'b0;
			o_msg          <= MSG_RST;
		end else if (i_clk_en) begin
			o_send_enquiry <= 1'b0;
			o_send_packet  <= 1'b0;
			o_pass_token   <= 1'b0;
			if (wr_ctrl && cw[B_QUEUE] && !pending) begin
				pending <= 1'b1;
				o_msg   <= msg;
			end
			case (st)
				S_IDLE: begin
					if (i_token && go) begin
						if (pending) begin
							o_send_enquiry <= 1'b1;
							st             <= S_ENQ;
						end else
							o_pass_token <= 1'b1;
					end
				end
				S_ENQ: begin
					if (!go)
						st <= S_IDLE;
					else if (i_reply_ack) begin
						o_send_packet <= 1'b1;
						st            <= S_PKT;
					end else if (i_reply_refuse) begin
						o_pass_token <= 1'b1;
						st           <= S_IDLE;
						if (naks == NAK_LIMIT - 3'h1) begin
							pending <= 1'b0;
							naks    <= 3'h0;
							fails   <= 3'h0;
						end else
							naks <= naks + 3'h1;
					end
				end
				S_PKT: begin
					if (!go)
						st <= S_IDLE;
					else if (i_reply_ack) begin
						pending      <= 1'b0;
						naks         <= 3'h0;
						fails        <= 3'h0;
						o_pass_token <= 1'b1;
						st           <= S_IDLE;
					end
				end
				default: st <= S_IDLE;
			endcase
			if (fail_ev && go) begin
				if (fails == FAIL_LIMIT - 3'h1) begin
					pending      <= 1'b0;
					naks         <= 3'h0;
					fails        <= 3'h0;
					o_pass_token <= 1'b1;
					st           <= S_IDLE;
				end else begin
					fails          <= fails + 3'h1;
					o_send_enquiry <= 1'b1;
					st             <= S_ENQ;
				end
			end
		end
	end

	// receiver buffers and replies
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			occ            <= 2'h0;
			o_reply_ack    <= 1'b0;
			o_reply_refuse <= 1'b0;
		end else if (i_clk_en) begin
			o_reply_ack    <= 1'b0;
			o_reply_refuse <= 1'b0;
			occ <= (occ & ~(wr_ctrl ? cw[B_REL +: 2] : 2'h0))
				| ((i_rx_packet_ok && !occ[0]) ? 2'h1 : 2'h0)
				| ((i_rx_packet_ok && occ[0] && !occ[1]) ? 2'h2 : 2'h0);
			if (i_rx_packet_ok)
				o_reply_ack <= (occ != 2'h3);
			else if (i_rx_enquiry) begin
				o_reply_ack    <= (occ != 2'h3);
				o_reply_refuse <= (occ == 2'h3);
			end
		end
	end

	// sync ownership
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			o_sync_gen <= 1'b0;
		else if (i_clk_en) begin
			if (i_sync_seen && o_sync_gen && auto_sync && i_sync_src < o_cfg.addr)
				o_sync_gen <= 1'b0;
			else if (wr_ctrl && cw[B_SYNCOF])
				o_sync_gen <= 1'b0;
			else if (wr_ctrl && cw[B_SYNCON])
				o_sync_gen <= 1'b1;
		end
	end

	// rebuild forcing and watchdog
	assign rb_timeout = i_rebuild_active && (rb_cnt == TW'(RB_CYCLES - 1));
	assign next_force = !joined || i_go_online || rb_timeout
		|| (wr_ctrl && (cw[B_FORCE] || cw[B_REJOIN]));

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_force_rebuild <= 1'b0;
			rb_cnt          <= '0;
			fault           <= 1'b0;
		end else if (i_clk_en) begin
			o_force_rebuild <= next_force;
			rb_cnt <= (i_rebuild_active && !rb_timeout) ? rb_cnt + TW'(1) : '0;
			if (rb_timeout)
				fault <= 1'b1;
			else if (wr_ctrl && cw[B_CLRF])
				fault <= 1'b0;
		end
	end

	// once per second status
	assign tick = i_clk_en && (sec_cnt == TW'(SEC_CYCLES - 1));

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sec_cnt                  <= '0;
			rb_win                   <= 1'b0;
			o_status                 <= STAT_OK;
			o_ring_rebuild_indicator <= 1'b0;
		end else if (i_clk_en) begin
			sec_cnt <= tick ? '0 : sec_cnt + TW'(1);
			if (i_rebuild_seen || i_rebuild_active || o_force_rebuild)
				rb_win <= 1'b1;
			else if (tick)
				rb_win <= 1'b0;
			if (tick) begin
				o_status                 <= rb_win ? STAT_RB : STAT_OK;
				o_ring_rebuild_indicator <= rb_win;
			end
		end
	end

	// diagnostic counters
	always_comb begin
		inc            = '0;
		inc[C_REFUSED] = (st == S_ENQ) && go && i_reply_refuse && !i_reply_ack
			&& (naks == NAK_LIMIT - 3'h1);
		inc[C_DUPSYNC] = i_sync_seen && o_sync_gen;
		inc[C_SELF]    = o_force_rebuild;
		inc[C_PROC]    = i_rx_packet_ok && i_rx_noncyclic && (occ != 2'h3);
		inc[C_FWDFAIL] = fail_ev && go && o_msg.fwd;
		inc[C_DETECT]  = i_rebuild_seen;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < CNT_N; i++)
				cnt[i] <= 16'h0000;
		end else if (i_clk_en) begin
			for (int i = 0; i < CNT_N; i++)
				cnt[i] <= cnt[i] + 16'(inc[i]);
		end
	end

	// checks
	chk_enquiry_first: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && st == S_IDLE && i_token && pending && go |=> o_send_enquiry && st == S_ENQ)
		else $error("token with pending message gave no enquiry");
	chk_packet_after_ack: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && st == S_ENQ && go && i_reply_ack && !i_reply_none
		|=> o_send_packet && st == S_PKT)
		else $error("positive enquiry reply gave no packet");
	chk_delivery_pass: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && st == S_PKT && go && i_reply_ack && !i_reply_none
		|=> o_pass_token && !pending && naks == 3'h0)
		else $error("delivered message not closed");
	chk_refuse_retry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && st == S_ENQ && go && i_reply_refuse && !i_reply_ack
		&& naks < NAK_LIMIT - 3'h1 |=> o_pass_token && pending && st == S_IDLE)
		else $error("refused message not kept pending");
	chk_refuse_drop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		inc[C_REFUSED] && i_clk_en |=> !pending && cnt[C_REFUSED] == $past(cnt[C_REFUSED]) + 16'h1)
		else $error("fourth refusal not counted");
	chk_full_refuse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && i_rx_enquiry && !i_rx_packet_ok && occ == 2'h3 |=> o_reply_refuse && !o_reply_ack)
		else $error("full buffers did not refuse");
	chk_sync_yield: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && i_sync_seen && o_sync_gen && auto_sync && i_sync_src < o_cfg.addr
		|=> !o_sync_gen && cnt[C_DUPSYNC] == $past(cnt[C_DUPSYNC]) + 16'h1)
		else $error("sync not yielded to lower address");
	chk_self_count: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && o_force_rebuild |=> cnt[C_SELF] == $past(cnt[C_SELF]) + 16'h1)
		else $error("self forced rebuild not counted");
	chk_status_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!tick |=> $stable(o_status))
		else $error("status changed between ticks");
	chk_five_tries: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && fail_ev && go && fails == FAIL_LIMIT - 3'h1 |=> !pending && o_pass_token)
		else $error("message not abandoned after five failures");
	cov_delivered: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		st == S_PKT ##1 o_pass_token && !pending);
	cov_refuse_drop: cover property (@(posedge i_clock) disable iff (!i_rst_n) inc[C_REFUSED]);
	cov_rebuild_seen: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		tick && rb_win);

endmodule // tr_node

// *** dv/tr_far_node.sv ***
// Purpose: far ring node answering our enquiries and packets
// Assumes: one request pulse at a time, one reply per request
// Notes: mode 0 positive, 1 refusal, 2 silent; delay adds cycles
`timescale 1ns/10ps
module tr_far_node (
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire logic       i_req,
	input  wire logic [1:0] i_mode,
	input  wire logic [2:0] i_delay,
	output logic            o_ack,
	output logic            o_refuse,
	output logic            o_none
);
	logic [2:0] wait_cnt;
	logic       busy;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy     <= 1'b0;
			wait_cnt <= 3'h0;
			o_ack    <= 1'b0;
			o_refuse <= 1'b0;
			o_none   <= 1'b0;
		end else begin
			o_ack    <= 1'b0;
			o_refuse <= 1'b0;
			o_none   <= 1'b0;
			if (i_req) begin
				busy     <= 1'b1;
				wait_cnt <= i_delay;
			end else if (busy && wait_cnt != 3'h0) begin
				wait_cnt <= wait_cnt - 3'h1;
			end else if (busy) begin
				busy     <= 1'b0;
				o_ack    <= (i_mode == 2'h0);
				o_refuse <= (i_mode == 2'h1);
				o_none   <= (i_mode == 2'h2);
			end
		end
	end
endmodule // tr_far_node

// *** dv/tb_token_ring_message_diagnostics.sv ***
// Purpose: self-checking bench for the ring node handshake and counters
// Assumes: short second and rebuild windows set by parameters
// Notes: lfsr seeded at 53 feeds message and sync fields
`timescale 1ns/10ps
module tb_token_ring_message_diagnostics;
	import tr_node_pkg::*;
	logic        i_clock, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_rx_noncyclic, i_rebuild_active;
	logic        i_reply_ack, i_reply_refuse, i_reply_none, o_wb_ack, o_send_enquiry;
	logic        o_send_packet, o_pass_token, o_reply_ack, o_reply_refuse, o_force_rebuild;
	logic        o_sync_gen, o_ring_rebuild_indicator, i_clk_en;
	logic [7:0]  i_wb_adr, i_sync_src, rnd;
	logic [31:0] i_wb_dat, o_wb_dat, q;
	logic [3:0]  i_wb_sel;
	logic [15:0] o_status;
	logic [5:0]  pl;
	logic [1:0]  mode;
	logic [2:0]  dly;
	msg_t        o_msg;
	cfg_t        o_cfg;
	int          err_count = 0, checks_done = 0, n_enq = 0, n_pkt = 0, n_pass = 0;
	int          n_force = 0, n_rack = 0, n_rref = 0, i, n;

	tr_node #(.SEC_CYCLES(64), .RB_CYCLES(20)) DUT (.i_clock, .i_rst_n, .i_clk_en,
		.i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack,
		.i_token(pl[0]), .i_reply_ack, .i_reply_refuse, .i_reply_none, .i_rx_enquiry(pl[1]),
		.i_rx_packet_ok(pl[2]), .i_rx_noncyclic, .i_sync_seen(pl[3]), .i_sync_src,
		.i_rebuild_seen(pl[4]), .i_rebuild_active, .i_go_online(pl[5]), .o_send_enquiry,
		.o_send_packet, .o_msg, .o_pass_token, .o_reply_ack, .o_reply_refuse, .o_force_rebuild,
		.o_sync_gen, .o_status, .o_ring_rebuild_indicator, .o_cfg);

	tr_far_node far (.i_clock, .i_rst_n, .i_req(o_send_enquiry | o_send_packet), .i_mode(mode),
		.i_delay(dly), .o_ack(i_reply_ack), .o_refuse(i_reply_refuse), .o_none(i_reply_none));

	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		n_enq   += int'(o_send_enquiry === 1'b1);
		n_pkt   += int'(o_send_packet === 1'b1);
		n_pass  += int'(o_pass_token === 1'b1);
		n_force += int'(o_force_rebuild === 1'b1);
		n_rack  += int'(o_reply_ack === 1'b1);
		n_rref  += int'(o_reply_refuse === 1'b1);
	end

	function automatic logic [7:0] ca(input int c);
		return A_CNT + 8'(4 * c);
	endfunction

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'h3, w, a, d, 4'hF};
		do begin
			@(posedge i_clock);
		end while (o_wb_ack !== 1'b1);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask

	task fire(input int k);
		@(posedge i_clock);
		pl[k] <= 1'b1;
		@(posedge i_clock);
		pl <= 6'h0;
	endtask

	task idle(input int k);
		repeat (k) @(posedge i_clock);
	endtask

	task close_out;
		$display("checks=%0d errors=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge i_clock);
		err_count++;
		close_out;
	end

	initial begin
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = '0;
		{pl, i_rx_noncyclic, i_rebuild_active, i_sync_src, mode, dly} = '0;
		i_clk_en = 1'b1;
		rnd = 8'h35;
		i_rst_n = 1'b0;
		idle(4);
		i_rst_n <= 1'b1;
		idle(4);
		chk(32'(n_force), 32'h1);
		wb(0, ca(C_SELF), 32'h0); chk(q, 32'h1);
		wb(0, ca(C_PROC), 32'h0); chk(q, 32'h0);
		wb(0, 8'h40, 32'h0); chk(q, 32'h0);
		// delivery with prompt and slow far node
		for (i = 0; i < 2; i++) begin
			rnd = lfsr(rnd);
			dly <= 3'(i * 3);
			wb(1, A_MSG, {24'h100, rnd});
			wb(1, A_CTRL, 32'h1);
			fire(0);
			idle(20);
			chk(32'(o_msg.dest), 32'(rnd));
			chk(32'(n_pkt), 32'(i + 1));
			chk(32'(n_pass), 32'(i + 1));
		end
		// refusal on every attempt
		mode <= 2'h1;
		wb(1, A_MSG, 32'h207);
		wb(1, A_CTRL, 32'h1);
		for (i = 0; i < 4; i++) begin
			fire(0);
			idle(8);
			if (i == 2) begin
				wb(0, A_STATE, 32'h0); chk(32'({q[F_NAKS +: 3], q[F_PEND]}), 32'h7);
			end
		end
		chk(32'(n_pass), 32'h6);
		chk(32'(n_pkt), 32'h2);
		wb(0, ca(C_REFUSED), 32'h0); chk(q, 32'h1);
		wb(0, A_STATE, 32'h0); chk(32'(q[16]), 32'h0);
		// silent far node, forwarded message
		mode <= 2'h2;
		wb(1, A_MSG, 32'h409);
		wb(1, A_CTRL, 32'h1);
		fire(0);
		idle(40);
		chk(32'(n_enq), 32'h0B);
		chk(32'(n_pass), 32'h7);
		wb(0, ca(C_FWDFAIL), 32'h0); chk(q, 32'h5);
		// offline node ignores the token
		mode <= 2'h0;
		wb(1, A_CTRL, 32'h41);
		fire(0);
		idle(8);
		chk(32'(n_enq), 32'h0B);
		wb(1, A_CTRL, 32'h0);
		fire(0);
		idle(16);
		chk(32'(n_pass), 32'h8);
		chk(32'(n_force), 32'h1);
		// receive buffers
		i_rx_noncyclic <= 1'b1;
		fire(1); idle(2);
		chk(32'(n_rack), 32'h1);
		fire(2); fire(2); idle(2); fire(1); idle(2);
		chk(32'(n_rref), 32'h1);
		chk(32'(n_rack), 32'h3);
		wb(0, ca(C_PROC), 32'h0); chk(q, 32'h2);
		wb(1, A_CTRL, 32'h300);
		fire(1); idle(2);
		chk(32'(n_rack), 32'h4);
		// sync ownership
		wb(1, A_CTRL, 32'h6);
		rnd = lfsr(rnd);
		i_sync_src <= rnd | 8'h02;
		fire(3); idle(3);
		chk(32'(o_sync_gen), 32'h1);
		i_sync_src <= 8'h00;
		fire(3); idle(2);
		chk(32'(o_sync_gen), 32'h0);
		wb(0, ca(C_DUPSYNC), 32'h0); chk(q, 32'h2);
		// status held one second
		chk(32'(o_status), 32'h0);
		fire(4);
		n = 0;
		while (o_status !== 16'hFFFF && n < 80) begin @(posedge i_clock); n++; end
		chk(32'(o_ring_rebuild_indicator), 32'h1);
		n = 0;
		while (o_status === 16'hFFFF && n < 200) begin @(posedge i_clock); n++; end
		chk(32'(n), 32'h40);
		wb(0, ca(C_DETECT), 32'h0); chk(q, 32'h1);
		// forced rebuilds, rejoin and watchdog
		wb(1, A_CTRL, 32'h10);
		fire(5); idle(4);
		chk(32'(n_force), 32'h3);
		wb(0, ca(C_SELF), 32'h0); chk(q, 32'h3);
		wb(1, A_CFG, 32'h122); idle(2);
		chk(32'(o_cfg), 32'h1);
		wb(1, A_CTRL, 32'h20); idle(4);
		chk(32'(o_cfg), 32'h122);
		chk(32'(n_force), 32'h4);
		i_rebuild_active <= 1'b1;
		idle(30);
		i_rebuild_active <= 1'b0;
		chk(32'(n_force), 32'h5);
		wb(0, A_STATE, 32'h0); chk(32'(q[F_FAULT]), 32'h1);
		wb(1, A_CTRL, 32'h1000);
		wb(0, A_STATE, 32'h0); chk(32'(q[F_FAULT]), 32'h0);
		// frozen node ignores rebuild and packet
		i_clk_en <= 1'b0;
		fire(4); fire(2); idle(2);
		i_clk_en <= 1'b1;
		wb(0, ca(C_DETECT), 32'h0); chk(q, 32'h1);
		wb(0, ca(C_PROC), 32'h0); chk(q, 32'h2);
		close_out;
	end
endmodule // tb_token_ring_message_diagnostics
